// ---- pkg/bta_pkg.sv ----
// Purpose: Shared constants for the board test access logic.
// Assumes: Eight-bit parallel register port with a test space in the top
//          half of the address map.
// Notes:   Offsets, bit positions and reset values live here only.

// ==========================================================================
// Package
// ==========================================================================
package bta_pkg;

   // Address map and space selection.
   localparam int         ADDR_W          = 8;
   localparam int         DATA_W          = 8;
   localparam int         TEST_SPACE_BIT  = 7;
   localparam logic [7:0] MASTER_TEST     = 8'h80;
   localparam logic [7:0] TX_CELL_VIEW    = 8'h82;
   localparam logic [7:0] TX_CTL_VIEW     = 8'h83;
   localparam logic [7:0] RX_RATE_VIEW    = 8'h84;
   localparam logic [7:0] ALARM_FORCE     = 8'h90;
   localparam logic [7:0] IRQ_FORCE_A     = 8'h92;
   localparam logic [7:0] TX_FP_FORCE     = 8'h96;
   localparam logic [7:0] RX_CTL_FORCE    = 8'hd0;
   localparam logic [7:0] RX_CELL_FORCE   = 8'hd2;
   localparam logic [7:0] RX_CA_FORCE     = 8'he0;

   // Addresses that must be written with zero to arm the input/output mode.
   localparam int         ARM_N           = 7;
   localparam logic [7:0] ARM_VALUE       = 8'h00;
   localparam logic [ARM_N*8-1:0] ARM_ADDRS =
      {8'h91, 8'h95, 8'h99, 8'ha1, 8'hb1, 8'hd1, 8'he1};

   // Master test control bit positions.
   localparam int BIT_PINS_HIGH_Z    = 0;
   localparam int BIT_BUS_HIGH_Z     = 1;
   localparam int BIT_PIN_TEST       = 2;
   localparam int BIT_BUS_BY_SELECT  = 3;
   localparam int BIT_FACTORY_TEST   = 4;

   // Force register bit positions.
   localparam int BIT_ALARM          = 3;
   localparam int BIT_FRAME_PULSE    = 2;
   localparam int BIT_IRQ_A          = 6;
   localparam int BIT_TX_FP          = 0;
   localparam int BIT_RX_SOC         = 7;
   localparam int BIT_RX_CA          = 5;
   localparam int BIT_RX_CP          = 4;
   localparam int BIT_RX_GFC         = 3;
   localparam int BIT_RX_PARITY      = 1;
   localparam int BIT_IRQ_B          = 0;
   localparam int BIT_RX_CP_E        = 1;

   // Input view widths and the position of the rate field in its register.
   localparam int TX_CTL_W           = 7;
   localparam int RX_RATE_W          = 6;
   localparam int RX_RATE_LSB        = 2;

   // Vector clock edges needed before forced alarm and frame pulse settle.
   localparam int VECTOR_CLOCK_SETTLE        = 2;

   // Reset level of the control bits and of idle strobes.
   localparam logic [DATA_W-1:0] MASTER_RESET = 8'h00;
   localparam logic [2:0]        STROBE_IDLE  = 3'h7;

endpackage

// ---- design/bta_sync.sv ----
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level; no bus coherence is implied.
// Notes:   Only the second stage may be read by other logic.

`timescale 1ns/1ns

// ==========================================================================
// Synchroniser
// ==========================================================================
module bta_sync #(
   parameter int               WIDTH   = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // The first stage may go metastable, so only the second stage reads it.
   always_ff @(posedge clock) begin
      if (rst) begin
         stage1   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ---- design/bta_test_access.sv ----
// Purpose: Board test access logic behind the parallel register port.
// Assumes: Port pins arrive asynchronously; functional output values come
//          from core logic on the same clock.
// Notes:   Writes commit on the rising edge of the write strobe.

`timescale 1ns/1ns

module bta_test_access
   import bta_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Register port pins.
   input  wire logic                 chip_select_n,
   input  wire logic                 read_strobe_n,
   input  wire logic                 write_strobe_n,
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [DATA_W-1:0]    data_in,
   output logic      [DATA_W-1:0]    data_out,
   output logic                      data_oe_n,
   // Normal register space served by the core.
   input  wire logic [DATA_W-1:0]    normal_rd_data,
   output logic                      normal_wr_pulse,
   output logic                      sub_block_test,
   // Observed input pins.
   input  wire logic                 vector_clock,
   input  wire logic [7:0]           tx_cell_bus,
   input  wire logic [TX_CTL_W-1:0]  tx_ctl_in,
   input  wire logic [RX_RATE_W-1:0] rx_rate_in,
   // Functional values from the core.
   input  wire logic [7:0]           func_rx_cell_bus,
   input  wire logic                 func_rx_soc,
   input  wire logic                 func_rx_ca,
   input  wire logic                 func_rx_cp,
   input  wire logic                 func_rx_gfc,
   input  wire logic                 func_rx_parity,
   input  wire logic                 func_rx_alarm,
   input  wire logic                 func_rx_frame_pulse,
   input  wire logic                 func_tx_frame_pulse,
   input  wire logic                 func_irq,
   // Output pins.
   output logic      [7:0]           rx_cell_bus,
   output logic                      rx_soc,
   output logic                      rx_ca,
   output logic                      rx_cp,
   output logic                      rx_gfc,
   output logic                      rx_parity,
   output logic                      rx_alarm_out,
   output logic                      rx_frame_pulse,
   output logic                      tx_frame_pulse_out,
   output logic                      pins_oe_n,
   output logic                      irq_out_n,
   output logic                      irq_oe_n
);

   // =======================================================================
   // Pin synchronisers
   // =======================================================================
   localparam int SYNC_W = 3 + ADDR_W + DATA_W + 1 + 8 + TX_CTL_W
                           + RX_RATE_W;
   localparam logic [SYNC_W-1:0] SYNC_RST = {STROBE_IDLE,
                                             {(SYNC_W-3){1'b0}}};

   logic [SYNC_W-1:0]    sync_vec;
   logic                 cs_s;
   logic                 rd_s;
   logic                 wr_s;
   logic [ADDR_W-1:0]    addr_s;
   logic [DATA_W-1:0]    data_s;
   logic                 vector_clock_s;
   logic [7:0]           tdat_s;
   logic [TX_CTL_W-1:0]  txctl_s;
   logic [RX_RATE_W-1:0] rxrate_s;

   // One synchroniser covers every pin; strobes idle high out of reset.
   bta_sync #(
      .WIDTH   (SYNC_W),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in ({chip_select_n, read_strobe_n, write_strobe_n, addr,
                  data_in, vector_clock, tx_cell_bus, tx_ctl_in,
                  rx_rate_in}),
      .sync_out (sync_vec)
   );

   assign {cs_s, rd_s, wr_s, addr_s, data_s, vector_clock_s, tdat_s, txctl_s,
           rxrate_s} = sync_vec;

   // =======================================================================
   // Strobe decoding
   // =======================================================================
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic                wr_prev;
   logic                vector_clock_prev;
   logic [ADDR_W-1:0]   wr_addr;
   logic [DATA_W-1:0]   wr_data;
   logic                wr_open;
   logic                all_low;
   logic                wr_commit;
   logic                test_space;
   logic                rd_active;

   // All three strobes low is the board float request, not an access.
   assign all_low    = !cs_s && !rd_s && !wr_s;
   assign test_space = wr_addr[TEST_SPACE_BIT];
   assign wr_commit  = wr_s && !wr_prev && wr_open;
   assign rd_active  = !cs_s && !rd_s && wr_s;

   // Address and data are caught during the strobe so the rising edge
   // commits stable values even though the pins may already be moving.
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_prev <= 1'b1;
         wr_open <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end else begin
         wr_prev <= wr_s;
         if (!wr_s && !cs_s && rd_s) begin
            wr_open <= 1'b1;
            wr_addr <= addr_s;
            wr_data <= data_s;
         end else if (wr_s || all_low) begin
            wr_open <= 1'b0;
         end
      end
   end

   // Normal space writes are handed to the core as a single pulse.
   always_ff @(posedge clock) begin
      if (rst) begin
         normal_wr_pulse <= 1'b0;
      end else begin
         normal_wr_pulse <= wr_commit && !test_space;
      end
   end

   // =======================================================================
   // Master test control
   // =======================================================================
   logic pins_high_z;
   logic bus_high_z;
   logic pin_test_enable;
   logic bus_drive_by_select;
   logic factory_test_enable;
   logic master_wr;
   logic test_hold;

   assign master_wr = wr_commit && hit(wr_addr, MASTER_TEST);
   assign test_hold = pin_test_enable || factory_test_enable;

   // Unused bits seven to five are simply not stored.
   always_ff @(posedge clock) begin
      if (rst) begin
         pins_high_z         <= MASTER_RESET[BIT_PINS_HIGH_Z];
         bus_high_z          <= MASTER_RESET[BIT_BUS_HIGH_Z];
         pin_test_enable     <= MASTER_RESET[BIT_PIN_TEST];
         bus_drive_by_select <= MASTER_RESET[BIT_BUS_BY_SELECT];
      end else if (master_wr) begin
         pins_high_z         <= wr_data[BIT_PINS_HIGH_Z];
         bus_high_z          <= wr_data[BIT_BUS_HIGH_Z];
         pin_test_enable     <= wr_data[BIT_PIN_TEST];
         bus_drive_by_select <= wr_data[BIT_BUS_BY_SELECT];
      end
   end

   // Factory test has no reset term; its only clear is a high select level, which reset forces on cs_s.
   always_ff @(posedge clock) begin
      if (cs_s) begin
         factory_test_enable <= 1'b0;
      end else if (master_wr && wr_data[BIT_FACTORY_TEST]) begin
         factory_test_enable <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sub_block_test <= 1'b0;
      end else begin
         sub_block_test <= test_hold;
      end
   end

   // =======================================================================
   // Test mode arming
   // =======================================================================
   logic [ARM_N-1:0] armed;
   logic             tm0;

   // Each arming address is remembered until pin test is dropped.
   genvar g;
   generate
      for (g = 0; g < ARM_N; g++) begin : g_arm
         always_ff @(posedge clock) begin
            if (rst || !pin_test_enable) begin
               armed[g] <= 1'b0;
            end else if (wr_commit && wr_data == ARM_VALUE &&
                         hit(wr_addr, ARM_ADDRS[g*8 +: 8])) begin
               armed[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign tm0 = pin_test_enable && (&armed);

   // =======================================================================
   // Force registers
   // =======================================================================
   logic [7:0] frc_alarm;
   logic [7:0] frc_irq_a;
   logic [7:0] frc_tx_fp;
   logic [7:0] frc_rx_ctl;
   logic [7:0] frc_rx_cell;
   logic [7:0] frc_rx_ca;

   // Force values hold no reset value; they only matter once armed.
   always_ff @(posedge clock) begin
      if (wr_commit && tm0) begin
         if (hit(wr_addr, ALARM_FORCE))   frc_alarm   <= wr_data;
         if (hit(wr_addr, IRQ_FORCE_A))   frc_irq_a   <= wr_data;
         if (hit(wr_addr, TX_FP_FORCE))   frc_tx_fp   <= wr_data;
         if (hit(wr_addr, RX_CTL_FORCE))  frc_rx_ctl  <= wr_data;
         if (hit(wr_addr, RX_CELL_FORCE)) frc_rx_cell <= wr_data;
         if (hit(wr_addr, RX_CA_FORCE))   frc_rx_ca   <= wr_data;
      end
   end

   // Alarm and frame pulse forces pass a two-stage pipe on vector clock.
   logic [1:0] vpipe_alarm;
   logic [1:0] vpipe_fp;
   logic       vector_clock_rise;

   assign vector_clock_rise = vector_clock_s && !vector_clock_prev;

   always_ff @(posedge clock) begin
      if (rst) begin
         vector_clock_prev   <= 1'b0;
         vpipe_alarm <= '0;
         vpipe_fp    <= '0;
      end else begin
         vector_clock_prev <= vector_clock_s;
         if (vector_clock_rise) begin
            vpipe_alarm <= {vpipe_alarm[0], frc_alarm[BIT_ALARM]};
            vpipe_fp    <= {vpipe_fp[0], frc_alarm[BIT_FRAME_PULSE]};
         end
      end
   end

   // =======================================================================
   // Output selection
   // =======================================================================
   logic [15:0] func_vec;
   logic [15:0] force_vec;
   logic [15:0] next_out;
   logic        next_irq;
   logic        force_irq;

   assign func_vec  = {func_rx_cell_bus, func_rx_soc, func_rx_ca,
                       func_rx_cp, func_rx_gfc, func_rx_parity,
                       func_rx_alarm, func_rx_frame_pulse,
                       func_tx_frame_pulse};
   assign force_vec = {frc_rx_cell, frc_rx_ctl[BIT_RX_SOC],
                       frc_rx_ctl[BIT_RX_CA],
                       frc_rx_ctl[BIT_RX_CP] || frc_rx_ca[BIT_RX_CP_E],
                       frc_rx_ctl[BIT_RX_GFC], frc_rx_ctl[BIT_RX_PARITY],
                       vpipe_alarm[VECTOR_CLOCK_SETTLE-1],
                       vpipe_fp[VECTOR_CLOCK_SETTLE-1],
                       frc_tx_fp[BIT_TX_FP]};
   assign force_irq = frc_irq_a[BIT_IRQ_A] || frc_rx_ctl[BIT_IRQ_B];
   // Functional values win unless armed test mode is in force.
   assign next_out  = tm0 ? force_vec : func_vec;
   assign next_irq  = tm0 ? force_irq : func_irq;

   logic [15:0] out_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         out_q     <= '0;
         irq_oe_n  <= 1'b1;
         irq_out_n <= 1'b0;
         pins_oe_n <= 1'b1;
      end else begin
         out_q     <= next_out;
         irq_out_n <= 1'b0;
         // Open drain: only pull low, float otherwise.
         irq_oe_n  <= !next_irq || pins_high_z || all_low;
         pins_oe_n <= pins_high_z || all_low;
      end
   end

   // Clock and serial line outputs stay outside this block entirely.
   assign {rx_cell_bus, rx_soc, rx_ca, rx_cp, rx_gfc, rx_parity,
           rx_alarm_out, rx_frame_pulse, tx_frame_pulse_out} = out_q;

   // =======================================================================
   // Read path and data bus enable
   // =======================================================================
   logic [DATA_W-1:0] test_rd;
   logic [DATA_W-1:0] next_rd;
   logic              bus_drive;

   // Only the two readable master bits return; unused bits read zero.
   assign test_rd =
      hit(addr_s, MASTER_TEST) ?
         {5'h00, pin_test_enable, 1'b0, pins_high_z} :
      (tm0 && hit(addr_s, TX_CELL_VIEW)) ? tdat_s :
      (tm0 && hit(addr_s, TX_CTL_VIEW))  ? {1'b0, txctl_s} :
      (tm0 && hit(addr_s, RX_RATE_VIEW)) ?
         {rxrate_s, {RX_RATE_LSB{1'b0}}} : 8'h00;
   assign next_rd = addr_s[TEST_SPACE_BIT] ? test_rd : normal_rd_data;

   // Drive-by-select needs pin test and then overrides bus float.
   assign bus_drive =
      all_low ? 1'b0 :
      (pin_test_enable && bus_drive_by_select) ? cs_s :
      bus_high_z ? 1'b0 :
      rd_active;

   // The bus enable lags the pins by the synchroniser delay, a trade for
   // never reading a metastable strobe.
   always_ff @(posedge clock) begin
      if (rst) begin
         data_out  <= '0;
         data_oe_n <= 1'b1;
      end else begin
         data_oe_n <= !bus_drive;
         if (rd_active) begin
            data_out <= next_rd;
         end
      end
   end

endmodule

// ---- test/bta_monitor.sv ----
// Purpose: Port checker for the board test access logic.
// Assumes: Host holds address until the next access begins.
// Notes:   Depths allow for the two-flop synchroniser on the pins.
`timescale 1ns/1ns
// ======================================================================
// Checker
// ======================================================================
module bta_monitor
   import bta_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst,
   input wire logic              chip_select_n,
   input wire logic              read_strobe_n,
   input wire logic              write_strobe_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic              data_oe_n,
   input wire logic              normal_wr_pulse,
   input wire logic              sub_block_test,
   input wire logic              pins_oe_n,
   input wire logic              irq_out_n,
   input wire logic              irq_oe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Strobe patterns held long enough to pass the synchroniser.
   sequence s_all_low;
      (!chip_select_n && !read_strobe_n && !write_strobe_n) [*5];
   endsequence
   sequence s_writing;
      (!chip_select_n && read_strobe_n && !write_strobe_n) [*5];
   endsequence
   property p_float_all; s_all_low |-> data_oe_n && pins_oe_n; endproperty
   a_float_all: assert property (p_float_all)
      else $error("pins driven while all strobes low");
   property p_bus_cause;
      $fell(data_oe_n) |-> $past(chip_select_n, 2)
         || !$past(read_strobe_n, 2);
   endproperty
   a_bus_cause: assert property (p_bus_cause)
      else $error("bus driven without read or high select");
   property p_norm_space;
      normal_wr_pulse |-> !addr[TEST_SPACE_BIT];
   endproperty
   a_norm_space: assert property (p_norm_space)
      else $error("normal write pulse for a test address");
   // A committed write follows a full low then high strobe.
   property p_norm_timing;
      normal_wr_pulse |-> $past(write_strobe_n, 3)
         && !$past(write_strobe_n, 7) ##1 !normal_wr_pulse;
   endproperty
   a_norm_timing: assert property (p_norm_timing)
      else $error("normal write pulse badly timed");
   property p_test_by_write;
      $rose(sub_block_test) |-> !chip_select_n;
   endproperty
   a_test_by_write: assert property (p_test_by_write)
      else $error("test level rose outside a selected access");
   property p_irq_level; irq_out_n == 1'b0; endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("open-drain value not low");
   property p_irq_pins; !irq_oe_n |-> !pins_oe_n; endproperty
   a_irq_pins: assert property (p_irq_pins)
      else $error("interrupt driven while pins float");
   property p_write_float; s_writing |-> data_oe_n; endproperty
   a_write_float: assert property (p_write_float)
      else $error("bus driven during a write");
endmodule
bind bta_test_access bta_monitor u_mon (.clock, .rst, .chip_select_n,
   .read_strobe_n, .write_strobe_n, .addr, .data_oe_n, .normal_wr_pulse,
   .sub_block_test, .pins_oe_n, .irq_out_n, .irq_oe_n);

// ---- test/bta_host_model.sv ----
// Purpose: Host processor model on the parallel register port.
// Assumes: Strobes low and high for at least three clocks.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/1ns
// ======================================================================
// Host model
// ======================================================================
module bta_host_model
(
   input  wire logic       clock,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n,
   output logic            chip_select_n,
   output logic            read_strobe_n,
   output logic            write_strobe_n,
   output logic [7:0]      addr,
   output logic [7:0]      data_in
);
   // Idle levels at time zero.
   initial begin
      {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
      addr = 8'h00;
      data_in = 8'h5a;
   end
   // The trailing delay keeps later sampling clear of the edge.
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Select stays low after the strobe rises so the commit sees it.
   task automatic wr_hold(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      chip_select_n <= 1'b0;
      write_strobe_n <= 1'b0;
      addr <= a;
      data_in <= d;
      repeat (5) @(posedge clock);
      write_strobe_n <= 1'b1;
      idle(5);
   endtask
   task automatic deselect;
      @(posedge clock);
      chip_select_n <= 1'b1;
      data_in <= ~data_in;
      idle(4);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v,
                     output logic oe);
      @(posedge clock);
      chip_select_n <= 1'b0;
      read_strobe_n <= 1'b0;
      addr <= a;
      repeat (6) @(posedge clock);
      v = data_out;
      oe = data_oe_n;
      read_strobe_n <= 1'b1;
      idle(4);
      deselect();
   endtask
   task automatic all_low(input logic lvl);
      @(posedge clock);
      {chip_select_n, read_strobe_n, write_strobe_n} <= {3{lvl}};
      idle(6);
   endtask
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the board test access logic.
// Assumes: Host model tasks give the only port accesses.
// Notes:   Expected values come from the rules and package constants.
`timescale 1ns/1ns
// ======================================================================
// Bench
// ======================================================================
module tb;
   import bta_pkg::*;
   logic                 clock, rst, vector_clock, oe_v;
   logic                 chip_select_n, read_strobe_n, write_strobe_n;
   logic [7:0]           addr, data_in, data_out, rd_v, tx_cell_bus;
   logic [7:0]           normal_rd_data, func_cell, rx_cell_bus;
   logic [TX_CTL_W-1:0]  tx_ctl_in;
   logic [RX_RATE_W-1:0] rx_rate_in;
   logic [8:0]           fb;
   logic                 data_oe_n, normal_wr_pulse, sub_block_test;
   logic                 rx_soc, rx_ca, rx_cp, rx_gfc, rx_parity;
   logic                 rx_alarm_out, rx_frame_pulse, tx_frame_pulse_out;
   logic                 pins_oe_n, irq_out_n, irq_oe_n;
   int                   mismatches, n_compared, n_wr, cycles;
   logic [7:0]           fn_pins;
   assign fn_pins = {tx_frame_pulse_out, rx_frame_pulse, rx_alarm_out,
                     rx_parity, rx_gfc, rx_cp, rx_ca, rx_soc};
   bta_host_model host (.clock, .data_out, .data_oe_n, .chip_select_n,
      .read_strobe_n, .write_strobe_n, .addr, .data_in);
   bta_test_access DUT (.clock, .rst, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .addr, .data_in, .data_out, .data_oe_n,
      .normal_rd_data, .normal_wr_pulse, .sub_block_test, .vector_clock,
      .tx_cell_bus, .tx_ctl_in, .rx_rate_in, .func_rx_cell_bus(func_cell),
      .func_rx_soc(fb[0]), .func_rx_ca(fb[1]), .func_rx_cp(fb[2]),
      .func_rx_gfc(fb[3]), .func_rx_parity(fb[4]), .func_rx_alarm(fb[5]),
      .func_rx_frame_pulse(fb[6]), .func_tx_frame_pulse(fb[7]),
      .func_irq(fb[8]), .rx_cell_bus, .rx_soc, .rx_ca, .rx_cp, .rx_gfc,
      .rx_parity, .rx_alarm_out, .rx_frame_pulse, .tx_frame_pulse_out,
      .pins_oe_n, .irq_out_n, .irq_oe_n);
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Cycle ceiling well above the several hundred the sequence needs.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (normal_wr_pulse === 1'b1) n_wr <= n_wr + 1;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      host.wr_hold(a, d);
      host.deselect();
   endtask
   task automatic r(input logic [7:0] a);
      host.rd(a, rd_v, oe_v);
   endtask
   // Main sequence; each force write but the IRQ_FORCE_A clear is followed by its pin check.
   initial begin
      rst = 1'b1;
      {mismatches, n_compared, n_wr, cycles} = '0;
      {normal_rd_data, tx_cell_bus, func_cell} = {8'h6b, 8'ha5, 8'h96};
      {tx_ctl_in, rx_rate_in, fb} = {7'h5a, 6'h2d, 9'h155};
      vector_clock = 1'b0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      host.idle(4);
      r(MASTER_TEST);
      check("master after reset", rd_v, MASTER_RESET);
      w(8'h7f, 8'h11);
      check("normal writes", n_wr[7:0], 8'h01);
      r(8'h55);
      check("normal read", rd_v, 8'h6b);
      w(MASTER_TEST, 8'h01);
      check("pins float", pins_oe_n, 1'b1);
      r(MASTER_TEST);
      check("port live in float", rd_v, 8'h01);
      w(MASTER_TEST, 8'h02);
      r(MASTER_TEST);
      check("bus float", oe_v, 1'b1);
      check("functional cell bus", rx_cell_bus, func_cell);
      w(MASTER_TEST, 8'he4);
      check("sub block test", sub_block_test, 1'b1);
      r(MASTER_TEST);
      check("unused bits", rd_v, 8'h04);
      for (int i = 0; i < ARM_N; i++) begin
         w(ARM_ADDRS[i*8 +: 8], ARM_VALUE);
      end
      check("test writes", n_wr[7:0], 8'h01);
      // Second pass sees every observed input bit flipped.
      repeat (2) begin
         r(TX_CELL_VIEW);
         check("cell input view", rd_v, tx_cell_bus);
         r(TX_CTL_VIEW);
         check("control input view", rd_v, {1'b0, tx_ctl_in});
         r(RX_RATE_VIEW);
         check("rate input view", rd_v, {rx_rate_in, 2'b00});
         @(posedge clock);
         {tx_cell_bus, tx_ctl_in, rx_rate_in} <=
            ~{tx_cell_bus, tx_ctl_in, rx_rate_in};
      end
      r(8'h81);
      check("reserved read", rd_v, 8'h00);
      w(RX_CELL_FORCE, 8'h3c);
      check("forced cell bus", rx_cell_bus, 8'h3c);
      w(IRQ_FORCE_A, 8'h40);
      check("irq a pulled low", irq_oe_n, 1'b0);
      w(IRQ_FORCE_A, 8'h00);
      w(RX_CTL_FORCE, 8'hbb);
      check("forced control", fn_pins[4:0], 5'h1f);
      check("irq pulled low", irq_oe_n, 1'b0);
      w(RX_CTL_FORCE, 8'h00);
      check("control cleared", fn_pins[4:0], 5'h00);
      check("irq released", irq_oe_n, 1'b1);
      w(RX_CA_FORCE, 8'h02);
      check("forced cp alt", rx_cp, 1'b1);
      w(TX_FP_FORCE, 8'h01);
      check("forced tx pulse", tx_frame_pulse_out, 1'b1);
      w(ALARM_FORCE, 8'h0c);
      // The pair keeps its old value until the last required rise.
      for (int i = 1; i <= VECTOR_CLOCK_SETTLE; i++) begin
         @(posedge clock);
         vector_clock <= 1'b1;
         host.idle(4);
         @(posedge clock);
         vector_clock <= 1'b0;
         host.idle(4);
         check("alarm pair", fn_pins[6:5], {2{i == VECTOR_CLOCK_SETTLE}});
      end
      w(MASTER_TEST, 8'h0e);
      check("bus by high select", data_oe_n, 1'b0);
      host.wr_hold(ARM_ADDRS[7:0], ARM_VALUE);
      check("bus by low select", data_oe_n, 1'b1);
      host.deselect();
      w(MASTER_TEST, 8'h08);
      check("select control off", data_oe_n, 1'b1);
      check("functional soc", rx_soc, fb[0]);
      @(posedge clock);
      {func_cell, fb, normal_rd_data} <= ~{func_cell, fb, normal_rd_data};
      r(8'h2a);
      check("normal read flipped", rd_v, normal_rd_data);
      check("functional cell flipped", rx_cell_bus, func_cell);
      check("functional pins", fn_pins, fb[7:0]);
      check("functional irq", irq_oe_n, !fb[8]);
      host.all_low(1'b0);
      check("all low float", {data_oe_n, pins_oe_n}, 2'h3);
      host.all_low(1'b1);
      host.wr_hold(MASTER_TEST, 8'h10);
      check("factory test on", sub_block_test, 1'b1);
      host.deselect();
      check("factory test cleared", sub_block_test, 1'b0);
      w(MASTER_TEST, 8'h05);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      host.idle(4);
      r(MASTER_TEST);
      check("master after reset", rd_v, MASTER_RESET);
      print_verdict();
   end
endmodule
